// ==== design/core_act_defines.svh ====
// Timing constants and encodings for the core activation sequencer
`ifndef CORE_ACT_DEFINES_SVH
`define CORE_ACT_DEFINES_SVH

// Clock rate in kHz; cycles = ms * kHz
`define CAS_CLK_KHZ 20000
`define CAS_T_CR_MS 1000
`define CAS_T_CRSC_MS 500
`define CAS_T_CRSR_MS 1500
`define CAS_T_ACT_MS 15000
`define CAS_T_PAYLOAD_MS 1000
`define CAS_T_SILENCE_MS 2000
`define CAS_T_PLL_MS 5000
`define CAS_T_GLOBAL_MS 30000
// Rate factor for rate parameter above 12 and otherwise
`define CAS_BETA_HIGH 1
`define CAS_BETA_LOW 2
// Final frames sent before data mode
`define CAS_FINAL_FRAMES 2'h2
// Mapper levels in sixteenths, two's complement
`define CAS_LEVEL_W 6
`define CAS_LEVEL_POS 6'h09
`define CAS_LEVEL_NEG 6'h37
`define CAS_LEVEL_ZERO 6'h00
`define CAS_TIMER_W 32

`endif

// ==== design/core_act_pkg.sv ====
// Types shared by the core activation sequencer
package core_act_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_WAKE  = 4'h1,
    ST_GAP   = 4'h3,
    ST_SYNC  = 4'h2,
    ST_COEF  = 4'h6,
    ST_FINAL = 4'h7,
    ST_DATA  = 4'h5,
    ST_QUIET = 4'h4,
    ST_DRAIN = 4'hc
  } act_state_e;

endpackage

// ==== design/act_timer.sv ====
// Loadable down counter of symbol clock cycles with an expiry flag
`timescale 1ns/100ps
module act_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic stop,
  output logic expired
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic run_q;
  logic run_d;

  always_comb begin
    count_d = count_q;
    run_d = run_q;
    if (load) begin
      count_d = load_val;
      run_d = 1'b1;
    end else if (stop) begin
      run_d = 1'b0;
    end else if (run_q && count_q != '0) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
      run_q <= 1'b0;
    end else if (clk_en) begin
      count_q <= count_d;
      run_q <= run_d;
    end
  end

  assign expired = run_q && (count_q == '0);

endmodule

// ==== design/act_mapper.sv ====
// Two-level symbol mapper for activation signals
`timescale 1ns/100ps
`include "core_act_defines.svh"
module act_mapper (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic active,
  input wire logic bit_in,
  output logic [`CAS_LEVEL_W-1:0] level
);

  logic [`CAS_LEVEL_W-1:0] level_q;
  logic [`CAS_LEVEL_W-1:0] level_d;

  always_comb begin
    if (!active) begin
      level_d = `CAS_LEVEL_ZERO;
    end else if (bit_in) begin
      level_d = `CAS_LEVEL_POS;
    end else begin
      level_d = `CAS_LEVEL_NEG;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= `CAS_LEVEL_ZERO;
    end else if (clk_en) begin
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule

// ==== design/core_act_seq.sv ====
// Core activation sequencer for either end of the loop
`timescale 1ns/100ps
`include "core_act_defines.svh"
// How it works
// - Central sends all-ones sync a fixed gap after the remote wakeup ends.
// - Central not converging during its sync goes to the exception state.
// - Remote sends all-ones sync a fixed delay after its wakeup, same mask.
// - Remote lacking convergence or central coefficient frames during sync excepts.
// - Under loop timing the remote clock is locked from sync onward.
// - Central converged and past pull-in sends coefficient frames of framer bits.
// - Central missing remote coefficient frames while sending its own excepts.
// - Remote converged with central frames detected sends its coefficient frames.
// - Remote missing central final frames while sending coefficients excepts.
// - Central finishes current coefficient frame, final frames follow with no gap.
// - Final frames carry reversed sync word, arbitrary payload, CRC over it.
// - Central sends exactly two final frames.
// - From first final bit, received remote frame payload is ignored.
// - Both ends enter data mode within 200 symbols of the final frames ending.
// - Data mode start assumes no alignment to the last activation frame.
// - Payload is valid within the settle time after data mode starts.
// - Activation timeout, overall timeout or exception condition enters exception.
// - Exception: silent for quiet hold, wait far end silent, restart preactivation.
// - Timers or abnormal events raise exceptions; in data mode only abnormal events.
// - Scrambler bit 0 maps to -9/16, bit 1 to +9/16.
// - Activation timeout runs from remote wakeup start to remote data mode.
// - Quiet hold in exception state is at least 2 s.
// - Activation timeout is 15 times rate factor seconds.
// - Preactivation plus activation must finish within 30 s.
// - Pull-in interval from central sync start allows up to 5 s.
module core_act_seq #(
  parameter int unsigned CR_CYC = `CAS_T_CR_MS * `CAS_CLK_KHZ,
  parameter int unsigned CRSC_CYC = `CAS_T_CRSC_MS * `CAS_CLK_KHZ,
  parameter int unsigned CRSR_CYC = `CAS_T_CRSR_MS * `CAS_CLK_KHZ,
  parameter int unsigned ACT_CYC = `CAS_T_ACT_MS * `CAS_CLK_KHZ,
  parameter int unsigned PAYLOAD_CYC = `CAS_T_PAYLOAD_MS * `CAS_CLK_KHZ,
  parameter int unsigned SILENCE_CYC = `CAS_T_SILENCE_MS * `CAS_CLK_KHZ,
  parameter int unsigned PLL_CYC = `CAS_T_PLL_MS * `CAS_CLK_KHZ,
  parameter int unsigned GLOBAL_CYC = `CAS_T_GLOBAL_MS * `CAS_CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic is_central,
  input wire logic rate_high,
  input wire logic loop_timing_mode,
  input wire logic preact_start,
  input wire logic preact_done,
  input wire logic far_wakeup_det,
  input wire logic far_signal_present,
  input wire logic converged,
  input wire logic clock_locked,
  input wire logic coef_frames_det,
  input wire logic final_frames_det,
  input wire logic final_frames_end,
  input wire logic frame_bit,
  input wire logic frame_last_bit,
  input wire logic scr_bit,
  input wire logic abnormal_event,
  output logic tx_active,
  output logic [`CAS_LEVEL_W-1:0] tx_level,
  output logic scr_in,
  output logic frame_final,
  output logic mask_upstream,
  output logic loop_timed,
  output logic rx_payload_ignore,
  output logic data_mode,
  output logic payload_valid,
  output logic exception,
  output logic restart_preact,
  output logic [3:0] state
);

  localparam int TW = `CAS_TIMER_W;

  logic rst_meta_q;
  logic rst_sync_q;
  core_act_pkg::act_state_e state_q;
  core_act_pkg::act_state_e state_d;
  logic [1:0] final_cnt_q;
  logic [1:0] final_cnt_d;
  logic wake_seen_q;
  logic wake_seen_d;
  logic coef_pend_q;
  logic coef_pend_d;
  logic payload_valid_q;
  logic payload_valid_d;
  logic restart_q;
  logic restart_d;
  logic ignore_q;
  logic ignore_d;
  logic st_load;
  logic [TW-1:0] st_val;
  logic st_expired;
  logic act_load;
  logic act_stop;
  logic act_expired;
  logic glob_expired;
  logic except_now;
  logic entering;
  logic [TW-1:0] act_val;
  logic [TW-1:0] crsr_val;
  logic [TW-1:0] cr_val;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Rate-factor scaled durations
  assign act_val = TW'(ACT_CYC * (rate_high ? `CAS_BETA_HIGH : `CAS_BETA_LOW));
  assign crsr_val = TW'(CRSR_CYC * (rate_high ? `CAS_BETA_HIGH : `CAS_BETA_LOW));
  assign cr_val = TW'(CR_CYC * (rate_high ? `CAS_BETA_HIGH : `CAS_BETA_LOW));

  // Exception conditions during activation and data mode
  always_comb begin
    except_now = 1'b0;
    case (state_q)
      core_act_pkg::ST_WAKE, core_act_pkg::ST_GAP, core_act_pkg::ST_SYNC,
      core_act_pkg::ST_COEF, core_act_pkg::ST_FINAL: begin
        except_now = act_expired || glob_expired || abnormal_event;
      end
      core_act_pkg::ST_DATA: except_now = abnormal_event;
      default: except_now = 1'b0;
    endcase
  end

  // Main sequence
  always_comb begin
    state_d = state_q;
    final_cnt_d = final_cnt_q;
    wake_seen_d = wake_seen_q;
    coef_pend_d = coef_pend_q;
    payload_valid_d = payload_valid_q;
    ignore_d = ignore_q;
    restart_d = 1'b0;
    act_load = 1'b0;
    if (except_now) begin
      state_d = core_act_pkg::ST_QUIET;
    end else begin
      case (state_q)
        core_act_pkg::ST_IDLE: begin
          wake_seen_d = 1'b0;
          coef_pend_d = 1'b0;
          final_cnt_d = 2'h0;
          payload_valid_d = 1'b0;
          ignore_d = 1'b0;
          if (preact_done) begin
            state_d = core_act_pkg::ST_WAKE;
            act_load = !is_central;
          end
        end
        core_act_pkg::ST_WAKE: begin
          if (is_central) begin
            if (far_wakeup_det && !wake_seen_q) begin
              wake_seen_d = 1'b1;
              act_load = 1'b1;
            end
            if (wake_seen_q && !far_wakeup_det) begin
              state_d = core_act_pkg::ST_GAP;
            end
          end else if (st_expired) begin
            state_d = core_act_pkg::ST_GAP;
          end
        end
        core_act_pkg::ST_GAP: begin
          if (st_expired) begin
            state_d = core_act_pkg::ST_SYNC;
          end
        end
        core_act_pkg::ST_SYNC: begin
          if (is_central) begin
            if (st_expired && converged) begin
              state_d = core_act_pkg::ST_COEF;
            end
          end else if (loop_timing_mode && st_expired && !clock_locked) begin
            state_d = core_act_pkg::ST_QUIET;
          end else if (converged && coef_frames_det) begin
            state_d = core_act_pkg::ST_COEF;
          end
        end
        core_act_pkg::ST_COEF: begin
          if (is_central) begin
            if (coef_frames_det) begin
              coef_pend_d = 1'b1;
            end
            if ((coef_pend_q || coef_frames_det) && frame_last_bit) begin
              state_d = core_act_pkg::ST_FINAL;
              ignore_d = 1'b1;
            end
          end else if (final_frames_det) begin
            state_d = core_act_pkg::ST_FINAL;
          end
        end
        core_act_pkg::ST_FINAL: begin
          if (is_central) begin
            if (frame_last_bit) begin
              final_cnt_d = final_cnt_q + 2'h1;
              if (final_cnt_q + 2'h1 == `CAS_FINAL_FRAMES) begin
                state_d = core_act_pkg::ST_DATA;
              end
            end
          end else if (final_frames_end) begin
            state_d = core_act_pkg::ST_DATA;
          end
        end
        core_act_pkg::ST_DATA: begin
          if (st_expired) begin
            payload_valid_d = 1'b1;
          end
        end
        core_act_pkg::ST_QUIET: begin
          payload_valid_d = 1'b0;
          if (st_expired) begin
            state_d = core_act_pkg::ST_DRAIN;
          end
        end
        core_act_pkg::ST_DRAIN: begin
          if (!far_signal_present) begin
            state_d = core_act_pkg::ST_IDLE;
            restart_d = 1'b1;
          end
        end
        default: state_d = core_act_pkg::ST_IDLE;
      endcase
    end
  end

  // State timer loaded on entry to each timed state
  assign entering = (state_d != state_q);
  always_comb begin
    st_load = 1'b0;
    st_val = '0;
    if (entering) begin
      case (state_d)
        core_act_pkg::ST_WAKE: begin
          st_load = !is_central;
          st_val = cr_val;
        end
        core_act_pkg::ST_GAP: begin
          st_load = 1'b1;
          st_val = is_central ? TW'(CRSC_CYC) : crsr_val;
        end
        core_act_pkg::ST_SYNC: begin
          st_load = 1'b1;
          st_val = TW'(PLL_CYC);
        end
        core_act_pkg::ST_DATA: begin
          st_load = 1'b1;
          st_val = TW'(PAYLOAD_CYC);
        end
        core_act_pkg::ST_QUIET: begin
          st_load = 1'b1;
          st_val = TW'(SILENCE_CYC);
        end
        default: begin
          st_load = 1'b0;
          st_val = '0;
        end
      endcase
    end
  end

  assign act_stop = entering && (state_d == core_act_pkg::ST_DATA
                    || state_d == core_act_pkg::ST_QUIET);

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= core_act_pkg::ST_IDLE;
      final_cnt_q <= 2'h0;
      wake_seen_q <= 1'b0;
      coef_pend_q <= 1'b0;
      payload_valid_q <= 1'b0;
      restart_q <= 1'b0;
      ignore_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      final_cnt_q <= final_cnt_d;
      wake_seen_q <= wake_seen_d;
      coef_pend_q <= coef_pend_d;
      payload_valid_q <= payload_valid_d;
      restart_q <= restart_d;
      ignore_q <= ignore_d;
    end
  end

  // Symbol-cycle timers
  act_timer #(.W(TW)) u_state_timer (
    .clk(clk),
    .rst_b(rst_sync_q),
    .clk_en(clk_en),
    .load(st_load),
    .load_val(st_val),
    .stop(1'b0),
    .expired(st_expired)
  );

  act_timer #(.W(TW)) u_act_timer (
    .clk(clk),
    .rst_b(rst_sync_q),
    .clk_en(clk_en),
    .load(act_load),
    .load_val(act_val),
    .stop(act_stop),
    .expired(act_expired)
  );

  act_timer #(.W(TW)) u_global_timer (
    .clk(clk),
    .rst_b(rst_sync_q),
    .clk_en(clk_en),
    .load(preact_start && state_q == core_act_pkg::ST_IDLE),
    .load_val(TW'(GLOBAL_CYC)),
    .stop(act_stop),
    .expired(glob_expired)
  );

  // Transmit path: all-ones seed for wakeup and sync, framer bits in coefficient and final frames
  always_comb begin
    tx_active = 1'b0;
    scr_in = 1'b1;
    case (state_q)
      core_act_pkg::ST_WAKE: begin
        tx_active = !is_central;
      end
      core_act_pkg::ST_SYNC: begin
        tx_active = 1'b1;
      end
      core_act_pkg::ST_COEF, core_act_pkg::ST_FINAL: begin
        tx_active = 1'b1;
        scr_in = frame_bit;
      end
      default: begin
        tx_active = 1'b0;
        scr_in = 1'b1;
      end
    endcase
  end

  act_mapper u_mapper (
    .clk(clk),
    .rst_b(rst_sync_q),
    .clk_en(clk_en),
    .active(tx_active),
    .bit_in(scr_bit),
    .level(tx_level)
  );

  assign frame_final = is_central && state_q == core_act_pkg::ST_FINAL;
  assign mask_upstream = !is_central;
  assign loop_timed = !is_central && loop_timing_mode
                      && (state_q == core_act_pkg::ST_SYNC || state_q == core_act_pkg::ST_COEF
                      || state_q == core_act_pkg::ST_FINAL || state_q == core_act_pkg::ST_DATA);
  assign rx_payload_ignore = ignore_q;
  assign data_mode = state_q == core_act_pkg::ST_DATA;
  assign payload_valid = payload_valid_q;
  assign exception = state_q == core_act_pkg::ST_QUIET || state_q == core_act_pkg::ST_DRAIN;
  assign restart_preact = restart_q;
  assign state = state_q;

endmodule

// ==== testbench/core_act_monitor.sv ====
// Port checker for the core activation sequencer
`timescale 1ns/100ps
`include "core_act_defines.svh"
module core_act_monitor #(
  parameter int unsigned SILENCE_CYC = 40
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic is_central,
  input wire logic loop_timing_mode,
  input wire logic far_signal_present,
  input wire logic frame_bit,
  input wire logic frame_last_bit,
  input wire logic scr_bit,
  input wire logic tx_active,
  input wire logic [`CAS_LEVEL_W-1:0] tx_level,
  input wire logic scr_in,
  input wire logic frame_final,
  input wire logic loop_timed,
  input wire logic rx_payload_ignore,
  input wire logic data_mode,
  input wire logic exception,
  input wire logic [3:0] state
);
  logic [1:0] fin_q;
  logic [1:0] fin_d;
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Final frame last bits seen and cycles spent in the quiet state
  always_comb begin
    fin_d = 2'h0;
    quiet_d = 32'h0;
    if (state == 4'h7) fin_d = fin_q + {1'b0, clk_en & frame_last_bit};
    if (state == 4'h4) quiet_d = quiet_q + {31'h0, clk_en};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fin_q <= 2'h0;
      quiet_q <= 32'h0;
    end else begin
      fin_q <= fin_d;
      quiet_q <= quiet_d;
    end
  end
  chk_level_one: assert property (clk_en && tx_active && scr_bit |=> tx_level == 6'h09)
    else $error("Level wrong for bit one");
  chk_level_zero: assert property (clk_en && tx_active && !scr_bit |=> tx_level == 6'h37)
    else $error("Level wrong for bit zero");
  chk_ones_seed: assert property (
    (!is_central && state == 4'h1) || state == 4'h2 |-> scr_in && tx_active)
    else $error("Sync not fed with ones");
  chk_frame_feed: assert property (state == 4'h6 || state == 4'h7 |-> scr_in == frame_bit)
    else $error("Frames not fed to scrambler");
  chk_final_start: assert property (
    is_central && $rose(state == 4'h7) |-> frame_final && $past(frame_last_bit))
    else $error("Final frames off frame boundary");
  chk_two_finals: assert property (is_central && $rose(data_mode) |-> fin_q == 2'h2)
    else $error("Final frame count wrong");
  chk_ignore_rx: assert property (
    is_central && state == 4'h7 |=> state != 4'h7 || rx_payload_ignore)
    else $error("Received payload not ignored");
  chk_loop_lock: assert property (loop_timed == (!is_central && loop_timing_mode &&
    (state == 4'h2 || state == 4'h6 || state == 4'h7 || state == 4'h5)))
    else $error("Loop timing wrong");
  chk_quiet_hold: assert property ($fell(state == 4'h4) |-> quiet_q >= SILENCE_CYC)
    else $error("Quiet hold too short");
  chk_drain_exit: assert property (
    $fell(state == 4'hc) |-> !$past(far_signal_present) && state == 4'h0 && !exception)
    else $error("Restart while far end active");
endmodule

// ==== testbench/far_end_model.sv ====
// Peer transceiver at the far loop end
`timescale 1ns/100ps
module far_end_model #(
  parameter int WK = 20,
  parameter int DLY = 10,
  parameter int FR = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dut_central,
  input wire logic [3:0] dut_state,
  input wire logic wake_go,
  input wire logic respond,
  output logic far_wakeup_det,
  output logic far_signal_present,
  output logic coef_frames_det,
  output logic final_frames_det,
  output logic final_frames_end
);
  int wk;
  int dwell;
  logic [3:0] seen;
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wk <= 0;
      dwell <= 0;
      seen <= 4'h0;
      {far_wakeup_det, far_signal_present, coef_frames_det} <= 3'h0;
      {final_frames_det, final_frames_end} <= 2'h0;
    end else begin
      wk <= wake_go ? WK : (wk > 0 ? wk - 1 : 0);
      far_wakeup_det <= wk > 0;
      seen <= dut_state;
      dwell <= (dut_state == seen) ? dwell + 1 : 0;
      coef_frames_det <= respond && dwell >= DLY &&
        (dut_state == 4'h6 || (!dut_central && dut_state == 4'h2));
      final_frames_det <= respond && !dut_central && dut_state == 4'h6 && dwell >= DLY;
      final_frames_end <= !dut_central && dut_state == 4'h7 && dwell == 2 * FR;
      far_signal_present <= !(dut_state == 4'hc && seen == 4'hc && dwell >= 5);
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking testbench for the core activation sequencer
`timescale 1ns/100ps
`include "core_act_defines.svh"
module testbench;
  localparam int CRSC = 20;
  localparam int CRSR = 30;
  localparam int PV = 20;
  localparam int PLL = 30;
  logic clk, rst_b, clk_en, is_central, rate_high, loop_timing_mode, preact_start, preact_done;
  logic converged, clock_locked, frame_bit, frame_last_bit, scr_bit, abnormal_event;
  logic far_wakeup_det, far_signal_present, coef_frames_det, final_frames_det, final_frames_end;
  logic tx_active, scr_in, frame_final, mask_upstream, loop_timed, rx_payload_ignore;
  logic data_mode, payload_valid, exception, restart_preact, wake_go, respond;
  logic [`CAS_LEVEL_W-1:0] tx_level;
  logic [3:0] state;
  logic [7:0] fcnt;
  int mismatches = 0;
  int tests_run = 0;
  int restarts = 0;
  core_act_seq #(.CR_CYC(20), .CRSC_CYC(CRSC), .CRSR_CYC(CRSR), .ACT_CYC(900),
    .PAYLOAD_CYC(PV), .SILENCE_CYC(40), .PLL_CYC(PLL), .GLOBAL_CYC(5000)) u_core_act_seq (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .is_central(is_central), .rate_high(rate_high),
    .loop_timing_mode(loop_timing_mode), .preact_start(preact_start), .preact_done(preact_done),
    .far_wakeup_det(far_wakeup_det), .far_signal_present(far_signal_present),
    .converged(converged), .clock_locked(clock_locked), .coef_frames_det(coef_frames_det),
    .final_frames_det(final_frames_det), .final_frames_end(final_frames_end),
    .frame_bit(frame_bit), .frame_last_bit(frame_last_bit), .scr_bit(scr_bit),
    .abnormal_event(abnormal_event), .tx_active(tx_active), .tx_level(tx_level),
    .scr_in(scr_in), .frame_final(frame_final), .mask_upstream(mask_upstream),
    .loop_timed(loop_timed), .rx_payload_ignore(rx_payload_ignore), .data_mode(data_mode),
    .payload_valid(payload_valid), .exception(exception), .restart_preact(restart_preact),
    .state(state));
  far_end_model u_far_end_model (.clk(clk), .rst_b(rst_b), .dut_central(is_central),
    .dut_state(state), .wake_go(wake_go), .respond(respond), .far_wakeup_det(far_wakeup_det),
    .far_signal_present(far_signal_present), .coef_frames_det(coef_frames_det),
    .final_frames_det(final_frames_det), .final_frames_end(final_frames_end));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Stand-in framer and scrambler
  always @(negedge clk) begin
    if (!rst_b) begin
      {fcnt, frame_bit, frame_last_bit, scr_bit} <= 11'h000;
    end else begin
      fcnt <= fcnt + 8'h01;
      frame_last_bit <= fcnt[2:0] == 3'h7;
      frame_bit <= fcnt[1];
      scr_bit <= fcnt[0] ^ fcnt[3];
    end
  end
  always @(posedge clk) begin
    if (restart_preact === 1'b1) restarts <= restarts + 1;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim, output int n);
    n = 0;
    while (state !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(state === s, "State not reached");
  endtask
  task automatic start_run(input logic c, input logic rh);
    @(negedge clk);
    rst_b = 1'b0;
    is_central = c;
    rate_high = rh;
    respond <= 1'b1;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    preact_start = 1'b1;
    @(negedge clk);
    preact_start = 1'b0;
    preact_done = 1'b1;
    @(negedge clk);
    preact_done = 1'b0;
    wake_go <= c;
    @(negedge clk);
    wake_go <= 1'b0;
  endtask
  task automatic central_run();
    int n;
    start_run(1'b1, 1'b1);
    wait_st(4'h3, 60, n);
    wait_st(4'h2, 60, n);
    check(n >= CRSC - 1 && n <= CRSC + 2, "Sync gap");
    wait_st(4'h6, 90, n);
    check(n >= PLL - 1, "Sync too short");
    wait_st(4'h7, 60, n);
    wait_st(4'h5, 40, n);
    check(n == 16, "Final frames not two frames long");
    check(rx_payload_ignore === 1'b1 && loop_timed === 1'b0, "Data flags");
    repeat (PV) @(negedge clk);
    check(payload_valid === 1'b0, "Payload early");
    @(negedge clk);
    check(payload_valid === 1'b1, "Payload late");
    clk_en = 1'b0;
    abnormal_event = 1'b1;
    repeat (3) @(negedge clk);
    check(state === 4'h5, "Frozen state moved");
    clk_en = 1'b1;
    @(negedge clk);
    abnormal_event = 1'b0;
    check(exception === 1'b1 && tx_active === 1'b0, "No exception");
    $display("Test done: central activation");
  endtask
  task automatic remote_run();
    int n;
    for (int r = 0; r < 2; r++) begin
      loop_timing_mode = !r[0];
      start_run(1'b0, r[0]);
      wait_st(4'h3, 100, n);
      wait_st(4'h2, 100, n);
      check(n >= CRSR * (2 - r) - 1 && n <= CRSR * (2 - r) + 2, "Remote gap");
      check(loop_timed === !r[0] && mask_upstream === 1'b1, "Remote sync flags");
      wait_st(4'h6, 40, n);
      wait_st(4'h7, 40, n);
      wait_st(4'h5, 40, n);
      check(loop_timed === !r[0] && data_mode === 1'b1, "Remote data");
    end
    $display("Test done: remote activation");
  endtask
  task automatic unlocked_run();
    int n;
    clock_locked = 1'b0;
    loop_timing_mode = 1'b1;
    start_run(1'b0, 1'b1);
    respond <= 1'b0;
    wait_st(4'h2, 100, n);
    wait_st(4'h4, 60, n);
    check(n <= PLL + 2, "Lock loss late");
    clock_locked = 1'b1;
    $display("Test done: remote lock loss");
  endtask
  task automatic stall_run();
    int n;
    converged = 1'b0;
    for (int c = 0; c < 2; c++) begin
      start_run(c[0], 1'b1);
      wait_st(4'h2, 120, n);
      wait_st(4'h4, 1000, n);
      check(n >= 840 && n <= 870, "Activation timeout off");
    end
    converged = 1'b1;
    $display("Test done: activation timeout");
  endtask
  task automatic silent_peer_run();
    int n;
    int r0;
    r0 = restarts;
    start_run(1'b1, 1'b1);
    respond <= 1'b0;
    wait_st(4'h6, 200, n);
    wait_st(4'h4, 1000, n);
    @(negedge clk);
    check(tx_active === 1'b0 && tx_level === 6'h00, "Not silent");
    wait_st(4'h0, 200, n);
    repeat (2) @(negedge clk);
    check(restarts == r0 + 1, "No restart");
    $display("Test done: silent peer");
  endtask
  initial begin
    {rst_b, is_central, rate_high, loop_timing_mode, preact_start, preact_done} = 6'h00;
    {clk_en, converged, clock_locked, abnormal_event} = 4'he;
    respond <= 1'b1;
    wake_go <= 1'b0;
    central_run();
    remote_run();
    unlocked_run();
    stall_run();
    silent_peer_run();
    complete_run();
  end
  initial begin
    #(60000 * 50);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
bind core_act_seq core_act_monitor #(.SILENCE_CYC(SILENCE_CYC)) u_core_act_monitor (
  .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .is_central(is_central),
  .loop_timing_mode(loop_timing_mode), .far_signal_present(far_signal_present),
  .frame_bit(frame_bit), .frame_last_bit(frame_last_bit), .scr_bit(scr_bit),
  .tx_active(tx_active), .tx_level(tx_level), .scr_in(scr_in), .frame_final(frame_final),
  .loop_timed(loop_timed), .rx_payload_ignore(rx_payload_ignore), .data_mode(data_mode),
  .exception(exception), .state(state));
